// ==== hdl/frame_countdown.sv ====
`timescale 1ns/10ps
// Bit-time countdown, toggle copy and frame count
module frame_countdown (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          bit_tick,
    input  wire logic                          run,
    input  wire logic                          start,
    input  wire logic [13:0]                   bits_per_frame,
    input  wire logic                          interval_toggle,
    input  wire logic                          wr_en,
    input  wire logic [31:0]                   wr_data,
    output frame_timer_pkg::frame_state_t      state,
    output logic                               sof_pulse
);

    frame_timer_pkg::frame_state_t st_q;
    frame_timer_pkg::frame_state_t st_d;
    logic                          sof_q;
    logic                          sof_d;

    // Entry to operation wins over a software write, which wins over a tick
    always_comb
    begin
        st_d  = st_q;
        sof_d = 1'b0;
        if (start)
        begin
            st_d.countdown   = bits_per_frame;
            st_d.frame_count = st_q.frame_count + 16'h0001;
            sof_d            = 1'b1;
        end
        else if (wr_en)
        begin
            st_d.countdown   = wr_data[frame_timer_pkg::INTERVAL_W-1:0];
            st_d.toggle_copy = wr_data[frame_timer_pkg::TOGGLE_BIT];
        end
        else if (run && bit_tick)
        begin
            if (st_q.countdown == 14'h0000)
            begin
                st_d.countdown   = bits_per_frame;
                st_d.toggle_copy = interval_toggle;
                st_d.frame_count = st_q.frame_count + 16'h0001;
                sof_d            = 1'b1;
            end
            else
                st_d.countdown = st_q.countdown - 14'h0001;
        end
    end

    // State registers; wrap of frame_count is the natural 16-bit overflow
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q  <= '{toggle_copy: 1'b0, countdown: 14'h0000, frame_count: frame_timer_pkg::FRAME_NUM_RESET};
            sof_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            sof_q <= sof_d;
        end
    end

    assign state     = st_q;
    assign sof_pulse = sof_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence tick_s;
        run && bit_tick && !start && !wr_en;
    endsequence

    sequence reload_s;
        tick_s ##0 (st_q.countdown == 14'h0000);
    endsequence

    chk_count_down: assert property (tick_s ##0 (st_q.countdown != 14'h0000) |=>
        st_q.countdown == $past(st_q.countdown) - 14'h0001)
        else $error("countdown did not decrement");
    chk_reload_value: assert property (reload_s |=> st_q.countdown == $past(bits_per_frame))
        else $error("countdown did not reload");
    chk_toggle_copy: assert property (reload_s |=> st_q.toggle_copy == $past(interval_toggle))
        else $error("toggle copy missed");
    chk_frame_advance: assert property (reload_s |=>
        st_q.frame_count == $past(st_q.frame_count) + 16'h0001)
        else $error("frame count did not advance");
    // Back-to-back reloads keep the pulse high, so its fall is checked on its own
    chk_sof_reload: assert property ((reload_s or start) |=> sof_q)
        else $error("sof pulse missing");
    chk_sof_quiet: assert property (!start && !(run && bit_tick && !wr_en && st_q.countdown == 14'h0000) |=> !sof_q)
        else $error("sof pulse without reload");
    chk_oper_entry: assert property (start |=> st_q.countdown == $past(bits_per_frame))
        else $error("no reload on entering operation");

endmodule : frame_countdown

// ==== hdl/frame_timer_pkg.sv ====
package frame_timer_pkg;

    // Register indexes; the byte address is four times the index
    localparam logic [7:0]  IDX_CTRL          = 8'h00;
    localparam logic [7:0]  IDX_INTERVAL      = 8'h0D;
    localparam logic [7:0]  IDX_COUNTDOWN     = 8'h0E;
    localparam logic [7:0]  IDX_FRAME_NUM     = 8'h0F;
    localparam logic [7:0]  IDX_BUDGET        = 8'h10;
    // Command code of a write is the read code with this bit set
    localparam logic [7:0]  CMD_WRITE_FLAG    = 8'h80;

    // Field layout of interval_config_reg and countdown_reg, and width of the frame number register
    localparam int          INTERVAL_W        = 14;
    localparam int          BUDGET_LSB        = 16;
    localparam int          BUDGET_W          = 15;
    localparam int          TOGGLE_BIT        = 31;
    localparam int          FRAME_NUM_W       = 16;

    // Reset values
    localparam logic [13:0] INTERVAL_NOMINAL  = 14'h2EDF;
    localparam logic [14:0] BUDGET_RESET      = 15'h0000;
    localparam logic [15:0] FRAME_NUM_RESET   = 16'h0000;

    // Control register bits
    localparam int          CTRL_SOFT_RST_BIT = 0;
    localparam int          CTRL_OPER_BIT     = 1;

    // Frame counter state as seen by software
    typedef struct packed {
        logic        toggle_copy;
        logic [13:0] countdown;
        logic [15:0] frame_count;
    } frame_state_t;

    // Register index from an APB byte address
    function automatic logic [7:0] reg_index(input logic [11:0] addr);
        reg_index = addr[9:2];
    endfunction : reg_index

    // True when the byte address names a mapped register
    function automatic logic reg_mapped(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0)
            reg_mapped = 1'b0;
        else if (idx == IDX_CTRL || idx == IDX_INTERVAL || idx == IDX_COUNTDOWN)
            reg_mapped = 1'b1;
        else if (idx == IDX_FRAME_NUM || idx == IDX_BUDGET)
            reg_mapped = 1'b1;
        else
            reg_mapped = 1'b0;
    endfunction : reg_mapped

endpackage : frame_timer_pkg

// ==== hdl/usb_host_frame_timer.sv ====
`timescale 1ns/10ps
module usb_host_frame_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        bit_tick,
    input  wire logic        data_bit,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sof_pulse,
    output logic      [14:0] budget_left
);

    logic [31:0]                   interval_q;
    logic [31:0]                   interval_d;
    logic                          oper_q;
    logic                          oper_d;
    logic                          oper_prev_q;
    logic [14:0]                   budget_q;
    logic [14:0]                   budget_d;
    logic [31:0]                   prdata_q;
    logic [31:0]                   prdata_d;
    logic                          pready_q;
    logic                          pready_d;
    logic                          pslverr_q;
    logic                          pslverr_d;
    logic                          access_end;
    logic [7:0]                    cmd_code;
    logic                          addr_ok;
    logic                          soft_reset;
    logic                          cnt_wr;
    logic                          start;
    logic                          sof;
    frame_timer_pkg::frame_state_t fstate;

    // Command code: register index, write flag on top
    assign cmd_code   = frame_timer_pkg::reg_index(paddr) | (pwrite ? frame_timer_pkg::CMD_WRITE_FLAG : 8'h00);
    assign access_end = psel && penable && pready_q;
    assign soft_reset = access_end && frame_timer_pkg::reg_mapped(paddr)
                        && cmd_code == (frame_timer_pkg::IDX_CTRL | frame_timer_pkg::CMD_WRITE_FLAG)
                        && pwdata[frame_timer_pkg::CTRL_SOFT_RST_BIT];
    assign cnt_wr     = access_end && frame_timer_pkg::reg_mapped(paddr)
                        && cmd_code == (frame_timer_pkg::IDX_COUNTDOWN | frame_timer_pkg::CMD_WRITE_FLAG);
    // Edge of the operational bit; both flops clear on reset, so no false start
    assign start      = oper_q && !oper_prev_q;
    assign addr_ok    = frame_timer_pkg::reg_mapped(paddr);

    // One wait state per access; read data is latched as pready rises
    always_comb
    begin
        pready_d  = psel && penable && !pready_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (pready_d)
        begin
            pslverr_d = !frame_timer_pkg::reg_mapped(paddr);
            prdata_d  = 32'h0000_0000;
            // Index bits alone would alias misaligned or high addresses onto registers
            if (!addr_ok)
                prdata_d = 32'h0000_0000;
            else if (cmd_code == frame_timer_pkg::IDX_INTERVAL)
                prdata_d = interval_q;
            else if (cmd_code == frame_timer_pkg::IDX_COUNTDOWN)
                prdata_d = {fstate.toggle_copy, 17'h00000, fstate.countdown};
            else if (cmd_code == frame_timer_pkg::IDX_FRAME_NUM)
                prdata_d = {16'h0000, fstate.frame_count};
            else if (cmd_code == frame_timer_pkg::IDX_BUDGET)
                prdata_d = {17'h00000, budget_q};
            else if (cmd_code == frame_timer_pkg::IDX_CTRL)
                prdata_d = {30'h0000_0000, oper_q, 1'b0};
        end
    end

    // Interval and control; soft reset beats a same-cycle write of the field
    always_comb
    begin
        interval_d = interval_q;
        oper_d     = oper_q;
        if (access_end && frame_timer_pkg::reg_mapped(paddr))
        begin
            if (cmd_code == (frame_timer_pkg::IDX_INTERVAL | frame_timer_pkg::CMD_WRITE_FLAG))
                interval_d = {pwdata[31:16], 2'b00, pwdata[13:0]};
            else if (cmd_code == (frame_timer_pkg::IDX_CTRL | frame_timer_pkg::CMD_WRITE_FLAG))
                oper_d = pwdata[frame_timer_pkg::CTRL_OPER_BIT];
        end
        if (soft_reset)
        begin
            interval_d[frame_timer_pkg::INTERVAL_W-1:0] = frame_timer_pkg::INTERVAL_NOMINAL;
            oper_d = 1'b0;
        end
    end

    // Budget loads at every frame start; then counts moved bits to zero
    always_comb
    begin
        budget_d = budget_q;
        if (sof)
            budget_d = interval_q[frame_timer_pkg::BUDGET_LSB +: frame_timer_pkg::BUDGET_W];
        else if (data_bit && budget_q != 15'h0000)
            budget_d = budget_q - 15'h0001;
    end

    // Register stage for all state of this file
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            interval_q  <= {1'b0, frame_timer_pkg::BUDGET_RESET, 2'b00, frame_timer_pkg::INTERVAL_NOMINAL};
            oper_q      <= 1'b0;
            oper_prev_q <= 1'b0;
            budget_q    <= frame_timer_pkg::BUDGET_RESET;
            prdata_q    <= 32'h0000_0000;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
        end
        else
        begin
            interval_q  <= interval_d;
            oper_q      <= oper_d;
            oper_prev_q <= oper_q;
            budget_q    <= budget_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
        end
    end

    // Countdown engine runs only in the operational state
    frame_countdown u_countdown (
        .clk             (clk),
        .rst             (rst),
        .bit_tick        (bit_tick),
        .run             (oper_q),
        .start           (start),
        .bits_per_frame  (interval_q[frame_timer_pkg::INTERVAL_W-1:0]),
        .interval_toggle (interval_q[frame_timer_pkg::TOGGLE_BIT]),
        .wr_en           (cnt_wr),
        .wr_data         (pwdata),
        .state           (fstate),
        .sof_pulse       (sof)
    );

    // Every output is a flop; sof_pulse is the engine's registered pulse
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign sof_pulse   = sof;
    assign budget_left = budget_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_s(logic [7:0] idx);
        psel && penable && !pwrite && pready_q && frame_timer_pkg::reg_index(paddr) == idx
        && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
    endsequence

    chk_nominal_force: assert property (soft_reset |=> interval_q[13:0] == 14'h2EDF)
        else $error("soft reset did not restore interval");
    chk_interval_write: assert property (access_end && !soft_reset && pwrite && paddr == 12'h034 |=>
        interval_q == {$past(pwdata[31:16]), 2'b00, $past(pwdata[13:0])})
        else $error("interval write lost");
    chk_budget_load: assert property (sof |=> budget_q == $past(interval_q[30:16]))
        else $error("budget not loaded at frame start");
    chk_interval_read: assert property (rd_s(8'h0D) |-> prdata_q == $past(interval_q))
        else $error("interval read mismatch");
    chk_countdown_read: assert property (rd_s(8'h0E) |->
        prdata_q == {$past(fstate.toggle_copy), 17'h00000, $past(fstate.countdown)})
        else $error("countdown read mismatch");
    chk_apb_wait: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb answer timing wrong");

    // Setup cycle of a transfer is never answered; the wait state is fixed
    sequence setup_s;
        psel && !penable;
    endsequence

    chk_apb_setup: assert property (setup_s |=> !pready_q)
        else $error("apb answered during setup");
    // Read data must stand between answers so a slow master still sees it
    chk_prdata_hold: assert property (!(psel && penable && !pready_q) |=> prdata_q == $past(prdata_q))
        else $error("read data changed between answers");
    // Refused addresses: error flag, zero data, no register changes
    chk_misaligned_err: assert property (access_end && paddr[1:0] != 2'h0 |-> pslverr_q)
        else $error("misaligned access not refused");
    chk_refused_zero: assert property (access_end && !pwrite && pslverr_q |-> prdata_q == 32'h0000_0000)
        else $error("refused read returned data");
    chk_refused_write: assert property (access_end && pwrite && pslverr_q |=>
        interval_q == $past(interval_q) && oper_q == $past(oper_q))
        else $error("refused write changed a register");
    // Interval only moves on a bus access, never on its own
    chk_interval_keep: assert property (!access_end |=> interval_q == $past(interval_q))
        else $error("interval changed without access");
    // Soft reset also leaves the operational state
    chk_soft_oper: assert property (soft_reset |=> !oper_q)
        else $error("soft reset left timer running");
    // Control write sets or clears the operational state
    chk_oper_write: assert property (access_end && pwrite && paddr == 12'h000 && !soft_reset |=>
        oper_q == $past(pwdata[1]))
        else $error("operational bit write lost");
    // Budget counts moved bits down and parks at zero
    chk_budget_count: assert property (!sof && data_bit && budget_q != 15'h0000 |=>
        budget_q == $past(budget_q) - 15'h0001)
        else $error("budget did not count down");
    chk_budget_floor: assert property (!sof && budget_q == 15'h0000 |=> budget_q == 15'h0000)
        else $error("budget wrapped below zero");

endmodule : usb_host_frame_timer

// ==== tb/frame_sched_model.sv ====
`timescale 1ns/10ps
// Frame scheduler stand-in: bit-time ticks and bits moved by a transaction
module frame_sched_model (
    input  wire logic clk,
    output logic      bit_tick,
    output logic      data_bit
);
    // Quiet until a task asks for traffic
    initial
    begin
        bit_tick = 1'b0;
        data_bit = 1'b0;
    end

    // One-cycle ticks; gap gives a slow bit rate
    task send_ticks(input int n, input int gap);
        repeat (n)
        begin
            @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask : send_ticks

    // Tick held high for n edges, the fastest bit rate
    task tick_burst(input int n);
        @(posedge clk);
        bit_tick <= 1'b1;
        repeat (n) @(posedge clk);
        bit_tick <= 1'b0;
    endtask : tick_burst

    // One-cycle pulses per bit moved
    task send_bits(input int n);
        repeat (n)
        begin
            @(posedge clk);
            data_bit <= 1'b1;
            @(posedge clk);
            data_bit <= 1'b0;
        end
    endtask : send_bits
endmodule : frame_sched_model

// ==== tb/usb_host_frame_timer_tb.sv ====
`timescale 1ns/10ps
module usb_host_frame_timer_tb;
    localparam logic [11:0] A_CTL = {2'h0, frame_timer_pkg::IDX_CTRL, 2'h0};
    localparam logic [11:0] A_INT = {2'h0, frame_timer_pkg::IDX_INTERVAL, 2'h0};
    localparam logic [11:0] A_CNT = {2'h0, frame_timer_pkg::IDX_COUNTDOWN, 2'h0};
    localparam logic [11:0] A_FN  = {2'h0, frame_timer_pkg::IDX_FRAME_NUM, 2'h0};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        bit_tick;
    logic        data_bit;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sof_pulse;
    logic [14:0] budget_left;
    logic        err;
    int          bad_count = 0;
    int          checks = 0;
    int          sofs = 0;

    usb_host_frame_timer dut (.clk(clk), .rst(rst), .bit_tick(bit_tick), .data_bit(data_bit),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sof_pulse(sof_pulse),
        .budget_left(budget_left));
    frame_sched_model m (.clk(clk), .bit_tick(bit_tick), .data_bit(data_bit));

    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    // Count frame starts independently of the frame counter
    always @(posedge clk)
    begin
        if (sof_pulse === 1'b1)
            sofs++;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; idle edge first so no signal is driven twice in a step
    // Waits for pready however long it takes; only the watchdog ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        chk(r & mask, exp);
    endtask : rd

    task complete_run;
        $display("mismatches=%0d compares=%0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // Watchdog against a hung handshake
    initial
    begin
        repeat (90000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(A_INT, 32'h00002EDF, 32'hFFFFFFFF);
        rd(A_CNT, 32'h00000000, 32'hFFFFFFFF);
        wr(A_INT, 32'h80050005);
        rd(A_INT, 32'h80050005, 32'hFFFFFFFF);
        wr(A_CNT, 32'h00000003);
        rd(A_CNT, 32'h00000003, 32'hFFFFFFFF);
        wr(A_CTL, 32'h00000002);
        repeat (3) @(posedge clk);
        chk({17'h0, budget_left}, 32'h00000005);
        rd(A_CNT, 32'h00000005, 32'h00003FFF);
        rd(A_FN, 32'h00000001, 32'hFFFFFFFF);
        m.send_ticks(2, 2);
        rd(A_CNT, 32'h00000003, 32'h00003FFF);
        m.send_bits(2);
        @(posedge clk);
        chk({17'h0, budget_left}, 32'h00000003);
        m.send_ticks(4, 0);
        repeat (3) @(posedge clk);
        chk({17'h0, budget_left}, 32'h00000005);
        rd(A_CNT, 32'h80000005, 32'hFFFFFFFF);
        rd(A_FN, 32'h00000002, 32'hFFFFFFFF);
        chk(sofs, 32'h00000002);
        // Shortest frames so the frame count wraps inside the run
        wr(A_CNT, 32'h00000000);
        wr(A_INT, 32'h00050000);
        m.tick_burst(65536);
        rd(A_FN, 32'h00000002, 32'hFFFFFFFF);
        rd(A_CNT, 32'h00000000, 32'hFFFFFFFF);
        chk(sofs, 32'h00010002);
        rd(A_INT, 32'h00050000, 32'hFFFFFFFF);
        wr(A_CTL, 32'h00000001);
        rd(A_INT, 32'h00052EDF, 32'hFFFFFFFF);
        rd(A_CTL, 32'h00000000, 32'hFFFFFFFF);
        wr(A_INT, 32'h80050000);
        rd(A_INT, 32'h80050000, 32'hFFFFFFFF);
        wr(12'h036, 32'h00001234);
        chk({31'h0, err}, 32'h00000001);
        rd(12'h036, 32'h00000000, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h00000001);
        rd(12'h044, 32'h00000000, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h00000001);
        rd(A_INT, 32'h80050000, 32'hFFFFFFFF);
        complete_run();
    end
endmodule : usb_host_frame_timer_tb
